// ==== hdl/dtc_defs.vh ====
// Constants for the dual timer/counter block: register offsets, bit
// positions, reset values and the peripheral cycle length.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// Register byte offsets
`define DTC_OFS_CTRL 8'h00
`define DTC_OFS_MODE 8'h04
`define DTC_OFS_T0_LOW 8'h08
`define DTC_OFS_T0_HIGH 8'h0C
`define DTC_OFS_T1_LOW 8'h10
`define DTC_OFS_T1_HIGH 8'h14

// Control register bit positions
`define DTC_CTRL_EXT0_TYPE 0
`define DTC_CTRL_EXT0_FLAG 1
`define DTC_CTRL_EXT1_TYPE 2
`define DTC_CTRL_EXT1_FLAG 3
`define DTC_CTRL_T0_RUN 4
`define DTC_CTRL_T0_OVF 5
`define DTC_CTRL_T1_RUN 6
`define DTC_CTRL_T1_OVF 7

// Mode register bit positions
`define DTC_MODE_T0_LO 0
`define DTC_MODE_T0_HI 1
`define DTC_MODE_T0_CT 2
`define DTC_MODE_T0_GATE 3
`define DTC_MODE_T1_LO 4
`define DTC_MODE_T1_HI 5
`define DTC_MODE_T1_CT 6
`define DTC_MODE_T1_GATE 7

// Reset values
`define DTC_RST_CTRL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_COUNT 8'h00

// Peripheral cycle in clock periods
`define DTC_PER_CLKS 6

`endif

// ==== hdl/dtc_timers.v ====
// Two timer/counters with modes 0..3 behind an APB slave.
// Assumes one 10 MHz clock, count and gate pins asynchronous to it,
// and interrupt acknowledge pulses from the interrupt controller.
//
// Operation
// - Mode 0: 13-bit count, low five bits prescale by 32 into high byte
// - Mode 0: upper three low-byte bits do not count
// - Mode 1: low and high bytes cascade as one 16-bit counter
// - Mode 2: low byte counts, overflow sets flag and reloads from high byte
// - Mode 2 reload leaves high byte as is; new value used next time
// - Mode 2 overflow flag clears on interrupt service
// - Timer 0 mode 3: low byte is an 8-bit timer with timer 0 controls
// - Timer 0 mode 3: high byte counts clock/6, run by t1 run, sets t1 flag
// - Timer 1 in mode 3 stops and holds its count
// - Timer 1 uses upper mode nibble and control bits 2, 3, 6, 7
// - Timer 1 counts with run set, and regardless of run while timer 0 is in mode 3; with gate set, external irq1 pin also gates
// - Timer 1 wrap from all ones sets its overflow flag, except while timer 0 is in mode 3
// - Timer 1 overflows drive the serial baud tick
// - Timer 0 uses lower mode nibble and control bits 0, 1, 4, 5
// - Timer operation increments once per six clocks
// - Counter operation: pin sampled per cycle, high then low counts
// - Overflow flag set each overflow, cleared when vectoring
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
`include "dtc_defs.vh"

module dtc_timers (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External pins
  input wire t0_count_pin,
  input wire t1_count_pin,
  input wire ext_irq0_pin,
  input wire ext_irq1_pin,
  // Interrupt acknowledge pulses
  input wire t0_irq_ack,
  input wire t1_irq_ack,
  input wire ext_irq0_ack,
  input wire ext_irq1_ack,
  // Flags and baud tick
  output reg t0_irq,
  output reg t1_irq,
  output reg ext_irq0_req,
  output reg ext_irq1_req,
  output reg baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode stepping for modes 0..2, returns {overflow, high, low}
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg [4:0] pre;
    reg carry;
    begin
      pre = lo[4:0] + 5'h01;
      carry = (lo[4:0] == 5'h1f);
      case (mode)
        2'd0: begin
          dtc_step = {carry & (hi == 8'hff), hi + {7'h00, carry},
                      lo[7:5], pre};
        end
        2'd1: begin
          dtc_step = {1'b0, hi, lo} + 17'h0_0001;
        end
        2'd2: begin
          if (lo == 8'hff) begin
            dtc_step = {1'b1, hi, hi};
          end else begin
            dtc_step = {1'b0, hi, lo + 8'h01};
          end
        end
        default: begin
          dtc_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [3:0] pin_raw = {ext_irq1_pin, ext_irq0_pin, t1_count_pin, t0_count_pin};
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (rst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral cycle divider
  reg [2:0] div_q;
  wire tick = (div_q == 3'd0);
  always @(posedge mclk) begin
    if (rst) begin
      div_q <= 3'd0;
    end else if (div_q == `DTC_PER_CLKS - 1) begin
      div_q <= 3'd0;
    end else begin
      div_q <= div_q + 3'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] ctrl_q;
  reg [7:0] mode_q;
  reg [7:0] t0_low_byte_q;
  reg [7:0] t0_high_byte_q;
  reg [7:0] t1_low_byte_q;
  reg [7:0] t1_high_byte_q;
  reg [1:0] samp_q;
  reg [1:0] irq_prev_q;

  wire t0_run_bit = ctrl_q[`DTC_CTRL_T0_RUN];
  wire t1_run_bit = ctrl_q[`DTC_CTRL_T1_RUN];
  wire [1:0] t0_mode = {mode_q[`DTC_MODE_T0_HI], mode_q[`DTC_MODE_T0_LO]};
  wire [1:0] t1_mode = {mode_q[`DTC_MODE_T1_HI], mode_q[`DTC_MODE_T1_LO]};
  wire t0_count_source_select = mode_q[`DTC_MODE_T0_CT];
  wire t1_count_source_select = mode_q[`DTC_MODE_T1_CT];
  wire t0_gate_bit = mode_q[`DTC_MODE_T0_GATE];
  wire t1_gate_bit = mode_q[`DTC_MODE_T1_GATE];
  wire t0_split = (t0_mode == 2'd3);

  ////////////////////////////////////////////////////////////////////////////
  // Count enables
  wire [1:0] fall = samp_q & ~sync2_q[1:0];
  wire t0_en = t0_run_bit & (~t0_gate_bit | sync2_q[2]);
  wire t1_run_eff = t0_split ? 1'b1 : t1_run_bit;
  wire t1_en = t1_run_eff & (~t1_gate_bit | sync2_q[3]);
  wire inc0 = tick & t0_en & (t0_count_source_select ? fall[0] : 1'b1);
  wire inc1 = tick & t1_en & (t1_count_source_select ? fall[1] : 1'b1) &
              (t1_mode != 2'd3);
  wire inc0h = tick & t0_split & t1_run_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Counter next state
  reg [7:0] t0l_d;
  reg [7:0] t0h_d;
  reg [7:0] t1l_d;
  reg [7:0] t1h_d;
  reg ovf0;
  reg ovf0h;
  reg ovf1;
  always @* begin
    t0l_d = t0_low_byte_q;
    t0h_d = t0_high_byte_q;
    t1l_d = t1_low_byte_q;
    t1h_d = t1_high_byte_q;
    ovf0 = 1'b0;
    ovf0h = 1'b0;
    ovf1 = 1'b0;
    if (t0_split) begin
      if (inc0) begin
        {ovf0, t0l_d} = {1'b0, t0_low_byte_q} + 9'h001;
      end
      if (inc0h) begin
        {ovf0h, t0h_d} = {1'b0, t0_high_byte_q} + 9'h001;
      end
    end else if (inc0) begin
      {ovf0, t0h_d, t0l_d} = dtc_step(t0_mode, t0_high_byte_q, t0_low_byte_q);
    end
    if (inc1) begin
      {ovf1, t1h_d, t1l_d} = dtc_step(t1_mode, t1_high_byte_q, t1_low_byte_q);
    end
  end

  wire set_t0_ovf = ovf0;
  wire set_t1_ovf = t0_split ? ovf0h : ovf1;

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt flags
  wire [1:0] irq_fall = irq_prev_q & ~sync2_q[3:2];
  wire ext_irq0_type = ctrl_q[`DTC_CTRL_EXT0_TYPE];
  wire ext_irq1_type = ctrl_q[`DTC_CTRL_EXT1_TYPE];
  wire set_ext0_flag = ext_irq0_type ? irq_fall[0] : ~sync2_q[2];
  wire set_ext1_flag = ext_irq1_type ? irq_fall[1] : ~sync2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire acc = psel & penable;
  wire done = acc & pready;
  wire wr = done & pwrite & ~pslverr;
  wire hit = (paddr == `DTC_OFS_CTRL) | (paddr == `DTC_OFS_MODE) |
             (paddr == `DTC_OFS_T0_LOW) | (paddr == `DTC_OFS_T0_HIGH) |
             (paddr == `DTC_OFS_T1_LOW) | (paddr == `DTC_OFS_T1_HIGH);
  reg [7:0] rd_mux;
  always @* begin
    case (paddr)
      `DTC_OFS_CTRL: rd_mux = ctrl_q;
      `DTC_OFS_MODE: rd_mux = mode_q;
      `DTC_OFS_T0_LOW: rd_mux = t0_low_byte_q;
      `DTC_OFS_T0_HIGH: rd_mux = t0_high_byte_q;
      `DTC_OFS_T1_LOW: rd_mux = t1_low_byte_q;
      `DTC_OFS_T1_HIGH: rd_mux = t1_high_byte_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register and counter update
  reg [7:0] ctrl_d;
  always @* begin
    ctrl_d = ctrl_q;
    if (wr && paddr == `DTC_OFS_CTRL) begin
      ctrl_d = pwdata[7:0];
    end
    if (t0_irq_ack) begin
      ctrl_d[`DTC_CTRL_T0_OVF] = 1'b0;
    end
    if (t1_irq_ack) begin
      ctrl_d[`DTC_CTRL_T1_OVF] = 1'b0;
    end
    if (ext_irq0_ack && ext_irq0_type) begin
      ctrl_d[`DTC_CTRL_EXT0_FLAG] = 1'b0;
    end
    if (ext_irq1_ack && ext_irq1_type) begin
      ctrl_d[`DTC_CTRL_EXT1_FLAG] = 1'b0;
    end
    if (set_t0_ovf) begin
      ctrl_d[`DTC_CTRL_T0_OVF] = 1'b1;
    end
    if (set_t1_ovf) begin
      ctrl_d[`DTC_CTRL_T1_OVF] = 1'b1;
    end
    if (set_ext0_flag) begin
      ctrl_d[`DTC_CTRL_EXT0_FLAG] = 1'b1;
    end
    if (set_ext1_flag) begin
      ctrl_d[`DTC_CTRL_EXT1_FLAG] = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `DTC_RST_CTRL;
      mode_q <= `DTC_RST_MODE;
      t0_low_byte_q <= `DTC_RST_COUNT;
      t0_high_byte_q <= `DTC_RST_COUNT;
      t1_low_byte_q <= `DTC_RST_COUNT;
      t1_high_byte_q <= `DTC_RST_COUNT;
      samp_q <= 2'b11;
      irq_prev_q <= 2'b11;
      t0_irq <= 1'b0;
      t1_irq <= 1'b0;
      ext_irq0_req <= 1'b0;
      ext_irq1_req <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_prev_q <= sync2_q[3:2];
      if (tick) begin
        samp_q <= sync2_q[1:0];
      end
      if (wr && paddr == `DTC_OFS_MODE) begin
        mode_q <= pwdata[7:0];
      end
      t0_low_byte_q <= (wr && paddr == `DTC_OFS_T0_LOW) ? pwdata[7:0] : t0l_d;
      t0_high_byte_q <= (wr && paddr == `DTC_OFS_T0_HIGH) ? pwdata[7:0] : t0h_d;
      t1_low_byte_q <= (wr && paddr == `DTC_OFS_T1_LOW) ? pwdata[7:0] : t1l_d;
      t1_high_byte_q <= (wr && paddr == `DTC_OFS_T1_HIGH) ? pwdata[7:0] : t1h_d;
      t0_irq <= ctrl_d[`DTC_CTRL_T0_OVF];
      t1_irq <= ctrl_d[`DTC_CTRL_T1_OVF];
      ext_irq0_req <= ctrl_d[`DTC_CTRL_EXT0_FLAG];
      ext_irq1_req <= ctrl_d[`DTC_CTRL_EXT1_FLAG];
      baud_tick <= ovf1;
    end
  end

endmodule

// ==== tb/dtc_timers_assertions.sv ====
// Checker on the timer block ports
// Assumes writes land at the edge where pready is sampled high
`timescale 1ns/1ns
`include "dtc_defs.vh"
module dtc_timers_assertions (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Flags
  input wire t0_irq_ack,
  input wire t1_irq_ack,
  input wire t0_irq,
  input wire t1_irq,
  input wire baud_tick
);
  reg [7:0] mode_q;
  reg [7:0] ctrl_q;
  wire wr_done = psel && penable && pready && pwrite;
  wire t0m3 = mode_q[1:0] == 2'b11;
  wire t1_halt = mode_q[5:4] == 2'b11;
  ////////////////////////////////////////////////////////////////
  // Shadow of written mode and run bits
  always @(posedge mclk) begin
    if (rst) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
    end else if (wr_done && paddr == `DTC_OFS_MODE) begin
      mode_q <= pwdata[7:0];
    end else if (wr_done && paddr == `DTC_OFS_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  t0_ack_clear_a: assert property (t0_irq_ack |-> ##[1:2] !t0_irq)
    else $error("t0 flag stays set after ack");
  t1_ack_clear_a: assert property (t1_irq_ack |-> ##[1:2] !t1_irq)
    else $error("t1 flag stays set after ack");
  baud_flag_a: assert property (baud_tick && !t0m3 |-> ##[0:1] t1_irq)
    else $error("t1 overflow without flag");
  baud_spacing_a: assert property (baud_tick |=> !baud_tick [*5])
    else $error("t1 overflows closer than six clocks");
  halt_no_baud_a: assert property (t1_halt && $past(t1_halt) |-> !baud_tick)
    else $error("t1 counts while halted");
  stopped_no_baud_a: assert property (!ctrl_q[6] && !$past(ctrl_q[6])
    && !t0m3 && !$past(t0m3) |-> !baud_tick)
    else $error("t1 counts with run clear");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  cover property (baud_tick);
  cover property (t0_irq_ack && t0_irq);
  cover property (t0m3 && $rose(t1_irq));
endmodule

bind dtc_timers dtc_timers_assertions chk_u (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .t0_irq_ack(t0_irq_ack), .t1_irq_ack(t1_irq_ack),
  .t0_irq(t0_irq), .t1_irq(t1_irq), .baud_tick(baud_tick));

// ==== tb/dtc_pin_model.sv ====
// Model of the count and gate pins outside the device
// Assumes pins idle high, as with pull-ups
`timescale 1ns/1ns
module dtc_pin_model (
  // Clock
  input wire mclk,
  // Pins
  output logic t0_count_pin,
  output logic t1_count_pin,
  output logic ext_irq0_pin,
  output logic ext_irq1_pin
);
  initial begin
    {t1_count_pin, t0_count_pin} = 2'b11;
    {ext_irq1_pin, ext_irq0_pin} = 2'b11;
  end
  // Each level held at least one peripheral cycle
  task automatic pulses(input int ch, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge mclk);
      {t1_count_pin, t0_count_pin} <= (ch == 1) ? 2'b01 : 2'b10;
      repeat (hold) @(posedge mclk);
      {t1_count_pin, t0_count_pin} <= 2'b11;
    end
    repeat (24) @(posedge mclk);
  endtask
  task automatic gate(input logic g1);
    ext_irq1_pin <= g1;
    @(posedge mclk);
  endtask
endmodule

// ==== tb/dtc_timers_test.sv ====
// Testbench for the dual timer/counter block
// Assumes the pin model drives count and gate pins
`timescale 1ns/1ns
`include "dtc_defs.vh"
module dtc_timers_test;
  typedef struct {logic [7:0] a; logic [7:0] d; logic s;} dtc_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] ack_q = 2'b00;
  logic [31:0] rd, v;
  logic er;
  wire [31:0] prdata;
  wire pready, pslverr, t0p, t1p, g0, g1, t0_irq, t1_irq, baud_tick, e0q, e1q;
  int num_errors = 0;
  int checks = 0;
  int nb = 0;
  dtc_row_t rows [5] = '{'{`DTC_OFS_T0_LOW, 8'hA5, 1'b0}, '{`DTC_OFS_T1_HIGH, 8'h5A, 1'b0},
    '{`DTC_OFS_MODE, 8'h22, 1'b0}, '{8'h18, 8'hFF, 1'b1}, '{8'hFC, 8'h11, 1'b1}};
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (baud_tick === 1'b1) nb++;
  dtc_pin_model pm_u (.mclk(mclk), .t0_count_pin(t0p), .t1_count_pin(t1p),
    .ext_irq0_pin(g0), .ext_irq1_pin(g1));
  dtc_timers dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .t0_count_pin(t0p), .t1_count_pin(t1p), .ext_irq0_pin(g0),
    .ext_irq1_pin(g1), .t0_irq_ack(ack_q[0]), .t1_irq_ack(ack_q[1]), .ext_irq0_ack(1'b0),
    .ext_irq1_ack(1'b0), .t0_irq(t0_irq), .t1_irq(t1_irq), .ext_irq0_req(e0q),
    .ext_irq1_req(e1q), .baud_tick(baud_tick));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic ack(input logic [1:0] m);
    ack_q <= m;
    @(posedge mclk);
    ack_q <= 2'b00;
    repeat (2) @(posedge mclk);
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].s ? 32'h0 : {24'h0, rows[i].d});
      chk({31'h0, er}, {31'h0, rows[i].s});
    end
    wr(`DTC_OFS_MODE, 8'h05);
    wr(`DTC_OFS_T0_LOW, 8'hFE);
    wr(`DTC_OFS_T0_HIGH, 8'hFF);
    wr(`DTC_OFS_CTRL, 8'h10);
    pm_u.pulses(0, 3, 12);
    rdc(`DTC_OFS_T0_LOW, 32'h01);
    rdc(`DTC_OFS_T0_HIGH, 32'h00);
    chk({31'h0, t0_irq}, 32'h1);
    ack(2'b01);
    chk({31'h0, t0_irq}, 32'h0);
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, 8'h60);
    wr(`DTC_OFS_T1_HIGH, 8'hFD);
    wr(`DTC_OFS_T1_LOW, 8'hFE);
    wr(`DTC_OFS_CTRL, 8'h40);
    pm_u.pulses(1, 2, 6);
    rdc(`DTC_OFS_T1_LOW, 32'hFD);
    chk({31'h0, t1_irq}, 32'h1);
    ack(2'b10);
    chk({31'h0, t1_irq}, 32'h0);
    wr(`DTC_OFS_T1_HIGH, 8'hF0);
    pm_u.pulses(1, 3, 6);
    rdc(`DTC_OFS_T1_LOW, 32'hF0);
    rdc(`DTC_OFS_T1_HIGH, 32'hF0);
    chk(nb, 2);
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, 8'hC0);
    wr(`DTC_OFS_T1_LOW, 8'hFF);
    wr(`DTC_OFS_T1_HIGH, 8'h07);
    pm_u.gate(1'b0);
    wr(`DTC_OFS_CTRL, 8'h40);
    pm_u.pulses(1, 2, 6);
    rdc(`DTC_OFS_T1_HIGH, 32'h07);
    chk({31'h0, e1q}, 32'h1);
    pm_u.gate(1'b1);
    pm_u.pulses(1, 1, 6);
    rdc(`DTC_OFS_T1_HIGH, 32'h08);
    chk(rd & 32'hFFFF_FF00, 32'h0000_0000);
    apb(1'b0, `DTC_OFS_T1_LOW, 8'h00);
    chk(rd & 32'h0000_001F, 32'h0);
    chk(rd & 32'h0000_00E0, 32'h0000_00E0);
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, 8'h30);
    wr(`DTC_OFS_CTRL, 8'h40);
    apb(1'b0, `DTC_OFS_T1_LOW, 8'h00);
    v = rd;
    repeat (30) @(posedge mclk);
    rdc(`DTC_OFS_T1_LOW, v);
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, 8'h33);
    wr(`DTC_OFS_T0_HIGH, 8'hFE);
    wr(`DTC_OFS_CTRL, 8'h40);
    repeat (20) @(posedge mclk);
    chk({31'h0, t1_irq}, 32'h1);
    chk({31'h0, t0_irq}, 32'h0);
    chk(nb, 2);
    chk({30'h0, e1q, e0q}, 32'h0);
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, 8'h10);
    wr(`DTC_OFS_T1_LOW, 8'h00);
    wr(`DTC_OFS_T1_HIGH, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h40);
    repeat (56) @(posedge mclk);
    wr(`DTC_OFS_CTRL, 8'h00);
    rdc(`DTC_OFS_T1_LOW, 32'h0A);
    give_verdict();
  end
endmodule
